//--- bench/testbench.sv
// Bench for the watchdog core with a flag model.
// Assumes the bench pulses rst after each reset request.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 0, rst = 1, por = 1, wr = 0, rd = 0, idle = 0, pd = 0, tk = 1, tk_half = 0;
  logic [7:0] adr = 8'h00, wd = 8'h00;
  wire  [7:0] rdat;
  wire        wrst;
  int fail_count = 0, tests_run = 0, seed = 75596, m_hi = 0, m_sf = 0, m_of = 0, m_rn = 0, got;
  wdsr_core u_dut (.sys_clk(sys_clk), .rst(rst), .por(por), .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(adr),
    .sfr_wdata(wd), .sfr_rdata(rdat), .idle(idle), .power_down(pd), .system_timer_tick(tk), .wdt_reset(wrst));
  initial forever #12.5 sys_clk = ~sys_clk;
  // Half-rate system timer ticks when asked, to stretch the period
  always @(posedge sys_clk) tk <= tk_half ? ~tk : 1'b1;
  function automatic int xs(int s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH rdata exp %h got %h", e, g);
    end
  endtask
  task automatic chkn(int lo, int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH cycles exp %0d..%0d got %0d", lo, hi, got);
    end
  endtask
  // Data is registered; look just after the taking edge
  task automatic rdc(logic [7:0] a, logic [7:0] e, logic [7:0] m);
    rd <= 1;
    adr <= a;
    @(posedge sys_clk);
    rd <= 0;
    #1 chk(e & m, rdat & m);
    @(posedge sys_clk);
  endtask
  // Bit 3 is unused, so masked
  task automatic ctl();
    rdc(8'ha7, {m_hi[3:0], 1'b0, m_sf[0], m_of[0], m_rn[0]}, 8'hf7);
  endtask
  // Strobe stays high across a pair so the writes are back to back
  task automatic w2(logic [7:0] a1, d1, a2, d2, int n);
    wr <= 1;
    adr <= a1;
    wd <= d1;
    @(posedge sys_clk);
    if (n > 1) begin
      adr <= a2;
      wd <= d2;
      @(posedge sys_clk);
    end
    wr <= 0;
  endtask
  // Count edges up to a request, then feed it back as rst
  task automatic run(int n, int lo, int hi);
    got = 0;
    while (got < n) begin
      #1;
      if (wrst === 1'b1) break;
      @(posedge sys_clk);
      got++;
    end
    if (got < n) begin
      @(posedge sys_clk);
      rst <= 1;
      @(posedge sys_clk);
      rst <= 0;
      m_rn = 0;
    end
    chkn(lo, hi);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    por <= 0;
    ctl();
    rdc(8'ha6, 8'h00, 8'hff);
    // Random control writes; running bit must not follow
    repeat (3) begin
      seed = xs(seed);
      w2(8'ha7, seed[7:0], 8'ha7, seed[7:0], 1);
      m_hi = seed[7:4];
      m_sf = seed[2];
      m_of = seed[1];
      ctl();
    end
    w2(8'ha6, 8'h5a, 8'ha6, 8'ha5, 2);
    run(4, 0, 0);
    m_sf = 1;
    ctl();
    w2(8'ha7, 8'h00, 8'ha7, 8'h00, 1);
    {m_hi, m_sf, m_of} = 0;
    @(posedge sys_clk);
    seed = xs(seed);
    w2(8'ha6, 8'h1e, 8'ha6, seed[7:0] == 8'he1 ? 8'h00 : seed[7:0], 2);
    run(4, 0, 0);
    m_sf = 1;
    m_of = 1;
    ctl();
    w2(8'ha6, 8'h1e, 8'ha7, {m_hi[3:0], 4'h6}, 2);
    run(4, 0, 0);
    w2(8'ha7, 8'h00, 8'ha7, 8'h00, 1);
    {m_hi, m_sf, m_of} = 0;
    ctl();
    // Code 0, counting on through idle
    idle <= 1;
    w2(8'ha6, 8'h1e, 8'ha6, 8'he1, 2);
    m_rn = 1;
    ctl();
    run(17000, 16380, 16386);
    m_of = 1;
    ctl();
    idle <= 0;
    w2(8'ha7, 8'h10, 8'ha7, 8'h10, 1);
    m_hi = 1;
    m_of = 0;
    @(posedge sys_clk);
    w2(8'ha6, 8'h1e, 8'ha6, 8'he1, 2);
    idle <= 1;
    run(4000, 4000, 4000);
    idle <= 0;
    pd <= 1;
    run(4000, 4000, 4000);
    pd <= 0;
    run(12000, 12000, 12000);
    tk_half <= 1;
    w2(8'ha6, 8'h1e, 8'ha6, 8'he1, 2);
    run(34000, 32760, 32776);
    tk_half <= 0;
    m_of = 1;
    ctl();
    end_sim();
  end
  initial begin
    #2400000;
    fail_count++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire

//--- bench/wdsr_monitor.sv
// Checker on the watchdog core ports.
// Assumes one clock domain; bound to every wdsr_core.
`default_nettype none
module wdsr_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       wdt_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Key writes and control reads
  wire k  = sfr_wr && sfr_addr == 8'ha6;
  wire cr = sfr_rd && sfr_addr == 8'ha7;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  pulse_once_a: assert property (wdt_reset |=> !wdt_reset) else $error("pulse");
  soft_key_a: assert property (k && sfr_wdata == 8'h5a ##1 k && sfr_wdata == 8'ha5 |=> wdt_reset)
    else $error("soft");
  feed_ok_a: assert property (k && sfr_wdata == 8'h1e ##1 k && sfr_wdata == 8'he1 |=> !wdt_reset)
    else $error("feed");
  bad_key_a: assert property (k && sfr_wdata == 8'h1e ##1 k && sfr_wdata != 8'he1 |=> wdt_reset)
    else $error("bad");
  mid_write_a: assert property (k && sfr_wdata == 8'h1e ##1 sfr_wr && sfr_addr != 8'ha6 |=> wdt_reset)
    else $error("mid");
  run_set_a: assert property (k && sfr_wdata == 8'h1e ##1 k && sfr_wdata == 8'he1 ##1 cr |=> sfr_rdata[0])
    else $error("run");
  run_clear_a: assert property ($past(rst) && cr |=> !sfr_rdata[0]) else $error("stop");
  key_read_a: assert property (sfr_rd && sfr_addr == 8'ha6 |=> sfr_rdata == 8'h00) else $error("key");
  idle_bus_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00) else $error("bus");
endmodule // wdsr_monitor
bind wdsr_core wdsr_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wdt_reset(wdt_reset));
`default_nettype wire

//--- verilog/wdsr_core.v
// Watchdog timer with key-sequence feed and software reset.
// Assumes SFR writes/reads on sys_clk; rst is any system reset incl. its own pulse.
`default_nettype none
`include "wdsr_regs.vh"

// How it works
// - Counts one step on each system timer tick
// - Period select codes 16K up to 2048K
// - Period times system timer prescale plus one
// - Fourteen-bit counter behind seven-bit prescaler
// - Stopped after reset and in power-down
// - Overflow while running pulses internal reset
// - Key 1E then E1 starts, sets running
// - Running flag read-only, shows counting
// - Key 5A then A5 soft resets
// - Wrong key sequence resets, sets both flags
// - Overflow reset sets sticky overflow flag
// - Idle freeze bit holds count in idle
module wdsr_core (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        por,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        idle,
  input  wire        power_down,
  input  wire        system_timer_tick,
  output reg         wdt_reset
);
  reg  [2:0]  ps_r;
  reg         idle_freeze_r;
  reg         soft_reset_flag_r;
  reg         overflow_flag_r;
  reg         running_flag_r;
  reg  [13:0] cnt_r;
  reg  [2:0]  key_state_r;
  reg  [2:0]  key_state_nxt;
  reg  [13:0] cnt_nxt;
  reg         running_flag_nxt;
  wire        key_armed;
  wire        key_wr;
  wire        ctrl_wr;
  wire        other_wr;
  wire        feed_ok;
  wire        soft_ok;
  wire        key_bad;
  wire        step;
  wire        pre_tick;
  wire        cnt_tick;
  wire        cnt_ovf;
  wire [2:0]  pre_sel;

  // Key pair states, one-hot; the first byte decides which pair is open
  localparam [2:0] KEY_IDLE = 3'b001;                                      // No first byte held
  localparam [2:0] KEY_FEED = 3'b010;                                      // Feed/enable pair open
  localparam [2:0] KEY_SOFT = 3'b100;                                      // Soft reset pair open

  assign key_wr   = sfr_wr & (sfr_addr == `WDSR_ADDR_KEY);
  assign ctrl_wr  = sfr_wr & (sfr_addr == `WDSR_ADDR_CTRL);
  assign other_wr = sfr_wr & ~key_wr;

  // A pair is open while the sequencer is out of its idle state
  assign key_armed = (key_state_r != KEY_IDLE);

  // Pair decode of the second key byte against the open pair
  assign feed_ok = key_wr & (key_state_r == KEY_FEED)
                   & (sfr_wdata == `WDSR_KEY_FEED_2);
  assign soft_ok = key_wr & (key_state_r == KEY_SOFT)
                   & (sfr_wdata == `WDSR_KEY_SOFT_2);
  // Bad: wrong first byte, wrong second byte, or another write splitting a pair.
  // Reads never touch the sequencer, so software may poll between the bytes.
  assign key_bad = (key_wr & ~key_armed & (sfr_wdata != `WDSR_KEY_FEED_1)
                    & (sfr_wdata != `WDSR_KEY_SOFT_1))
                 | (key_wr & key_armed & ~feed_ok & ~soft_ok)
                 | (other_wr & key_armed);

  // Step qualifier: the system timer prescale tick stretches every count
  assign step = running_flag_r & ~power_down & ~(idle & idle_freeze_r)
                & system_timer_tick;

  // Prescaler taps 0..6 give 2^(ps) per counter step, 14-bit counter on top
  assign pre_sel = ps_r;

  wdsr_prescale #(
    .WIDTH (`WDSR_PRE_WIDTH)
  ) u_pre (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (feed_ok),
    .en      (step),
    .sel     (pre_sel),
    .tick    (pre_tick)
  );

  // Code 111 shifts the tap out of 7 bits; the mask then wraps to all ones,
  // so the prescaler still gives 128 steps per count without a wider adder
  assign cnt_tick = pre_tick;
  assign cnt_ovf = cnt_tick & (&cnt_r);

  // Key sequencer next state; any write closes an open pair
  always @* begin
    key_state_nxt = key_state_r;
    case (key_state_r)
      KEY_IDLE: begin
        if (key_wr & (sfr_wdata == `WDSR_KEY_FEED_1)) begin
          key_state_nxt = KEY_FEED;
        end else if (key_wr & (sfr_wdata == `WDSR_KEY_SOFT_1)) begin
          key_state_nxt = KEY_SOFT;
        end
      end
      KEY_FEED: begin
        if (sfr_wr) begin
          key_state_nxt = KEY_IDLE;
        end
      end
      KEY_SOFT: begin
        if (sfr_wr) begin
          key_state_nxt = KEY_IDLE;
        end
      end
      default: begin
        key_state_nxt = KEY_IDLE;                                          // Illegal code recovers
      end
    endcase
  end

  // Key sequencer state; a reset drops any half-written pair
  always @(posedge sys_clk) begin
    if (rst) begin
      key_state_r <= KEY_IDLE;
    end else begin
      key_state_r <= key_state_nxt;
    end
  end

  // Counter next value; a feed restarts the full period
  always @* begin
    cnt_nxt          = cnt_r;
    running_flag_nxt = running_flag_r;
    if (feed_ok) begin
      running_flag_nxt = 1'b1;
      cnt_nxt          = `WDSR_CNT_ZERO;
    end else if (cnt_tick) begin
      cnt_nxt          = cnt_r + 14'h0001;
    end
  end

  // Counter and running flag; any reset stops the watchdog
  always @(posedge sys_clk) begin
    if (rst) begin
      running_flag_r <= 1'b0;
      cnt_r          <= `WDSR_CNT_ZERO;
    end else begin
      running_flag_r <= running_flag_nxt;
      cnt_r          <= cnt_nxt;
    end
  end

  // Reset pulse: one cycle; rst then clears the cause.
  // The counter may wrap once before rst lands, which is harmless.
  always @(posedge sys_clk) begin
    if (rst) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= cnt_ovf | soft_ok | key_bad;
    end
  end

  // Control register; flags survive the watchdog's own reset, only por clears
  always @(posedge sys_clk) begin
    if (por) begin
      ps_r              <= 3'h0;
      idle_freeze_r     <= 1'b0;
      soft_reset_flag_r <= 1'b0;
      overflow_flag_r   <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ps_r              <= sfr_wdata[`WDSR_BIT_PS_HI:`WDSR_BIT_PS_LO];
        idle_freeze_r     <= sfr_wdata[`WDSR_BIT_IDLE];
        soft_reset_flag_r <= sfr_wdata[`WDSR_BIT_SOFT];
        overflow_flag_r   <= sfr_wdata[`WDSR_BIT_OVF];
      end
      // Set wins over a clearing write in the same cycle
      if (soft_ok | key_bad) begin
        soft_reset_flag_r <= 1'b1;
      end
      if (cnt_ovf | key_bad) begin
        overflow_flag_r <= 1'b1;
      end
    end
  end

  // Read mux; key register is write-only and reads zero
  always @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd & (sfr_addr == `WDSR_ADDR_CTRL)) begin
      sfr_rdata <= {ps_r, idle_freeze_r, 1'b0, soft_reset_flag_r,
                    overflow_flag_r, running_flag_r};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end
endmodule // wdsr_core

`default_nettype wire

//--- verilog/wdsr_prescale.v
// Programmable 7-bit prescaler of the watchdog, tick out on wrap.
// Assumes en marks the counted events; clear and enable from the core.
`default_nettype none

module wdsr_prescale #(
  parameter WIDTH = 7
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             clr,
  input  wire             en,
  input  wire [2:0]       sel,
  output wire             tick
);
  reg  [WIDTH-1:0] pre_r;
  wire [WIDTH-1:0] mask;

  // Taps 2^sel events per tick, so sel doubles the period
  assign mask = ({{(WIDTH-1){1'b0}}, 1'b1} << sel) - {{(WIDTH-1){1'b0}}, 1'b1};
  assign tick = en & ((pre_r & mask) == mask);

  // Free counter; wraps rather than reloads so one adder serves all taps
  always @(posedge sys_clk) begin
    if (rst | clr) begin
      pre_r <= {WIDTH{1'b0}};
    end else if (en) begin
      pre_r <= pre_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // wdsr_prescale

`default_nettype wire

//--- verilog/wdsr_regs.vh
// Register map, key codes and field positions of the watchdog with soft reset.
// Assumes an SFR-style byte bus on the CPU clock; included by bare name.
`ifndef WDSR_REGS_VH
`define WDSR_REGS_VH

`define WDSR_ADDR_KEY      8'ha6
`define WDSR_ADDR_CTRL     8'ha7
`define WDSR_CTRL_RESET    8'h00
`define WDSR_KEY_FEED_1    8'h1e
`define WDSR_KEY_FEED_2    8'he1
`define WDSR_KEY_SOFT_1    8'h5a
`define WDSR_KEY_SOFT_2    8'ha5
`define WDSR_BIT_PS_HI     7
`define WDSR_BIT_PS_LO     5
`define WDSR_BIT_IDLE      4
`define WDSR_BIT_SOFT      2
`define WDSR_BIT_OVF       1
`define WDSR_BIT_RUN       0
`define WDSR_PRE_WIDTH     7
`define WDSR_CNT_WIDTH     14
`define WDSR_PS_WIDTH      3
`define WDSR_PRE_ZERO      7'h00
`define WDSR_CNT_ZERO      14'h0000

`endif
